/* File: core/gauge_scan_pkg.sv */
// Shared constants, types and register map of the gauge coil scan sequencer
package gauge_scan_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_COILS  = 12;
  localparam int unsigned NUM_GAUGES = 6;
  localparam int unsigned MAG_W      = 8;
  localparam int unsigned ADDR_W     = 8;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_MAG_BASE    = 8'h20;
  localparam logic [7:0] IDX_DIR_BASE    = 8'h2E;
  localparam logic [7:0] IDX_MINOR_D_POL = 8'h33;
  localparam logic [7:0] IDX_GAUGE_EN    = 8'h34;
  localparam logic [7:0] IDX_SCAN_CTRL   = 8'h35;

  // ---------------------------------------------------------------
  // Scan control and status fields
  // ---------------------------------------------------------------
  localparam int unsigned SC_TRIG_BIT   = 0;
  localparam int unsigned SC_AUTO_BIT   = 1;
  localparam int unsigned SC_CLKSEL_LO  = 3;
  localparam int unsigned SC_CLKSEL_HI  = 4;
  localparam int unsigned SC_CLEAR_BIT  = 5;
  localparam int unsigned SC_FLAG_BIT   = 6;
  localparam int unsigned SC_IRQEN_BIT  = 7;
  localparam int unsigned POL_BIT       = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MAG_RESET      = 8'h00;
  localparam logic       POL_RESET      = 1'b0;
  localparam logic [5:0] GAUGE_EN_RESET = 6'h00;
  localparam logic [1:0] CLKSEL_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // Scan clock division
  // ---------------------------------------------------------------
  localparam int unsigned DIV_RATIO_0 = 512;
  localparam int unsigned DIV_RATIO_1 = 1024;
  localparam int unsigned DIV_RATIO_2 = 2048;
  localparam int unsigned DIV_RATIO_3 = 4096;
  localparam logic [11:0] DIV_LAST_0  = 12'(DIV_RATIO_0 - 1);
  localparam logic [11:0] DIV_LAST_1  = 12'(DIV_RATIO_1 - 1);
  localparam logic [11:0] DIV_LAST_2  = 12'(DIV_RATIO_2 - 1);
  localparam logic [11:0] DIV_LAST_3  = 12'(DIV_RATIO_3 - 1);

  // ---------------------------------------------------------------
  // Scan positions
  // ---------------------------------------------------------------
  localparam logic [3:0] FIRST_COIL = 4'h0;
  localparam logic [3:0] SYNC_COIL  = 4'hA;
  localparam logic [3:0] LAST_COIL  = 4'hB;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPEN = 3'h1,
    ST_LOAD = 3'h3,
    ST_CONV = 3'h2,
    ST_HOLD = 3'h6
  } seq_state_type;

  typedef struct packed {
    logic [MAG_W-1:0]     dac_data;
    logic [NUM_COILS-1:0] sh_close;
    logic [NUM_COILS-1:0] dir_neg_to_pos;
    logic [NUM_COILS-1:0] drive_en;
  } coil_drive_type;

endpackage : gauge_scan_pkg

/* File: core/scan_slot_divider.sv */
// Scan clock divider marking conversion point and end of each coil slot
`timescale 1ns/1ps
module scan_slot_divider
  import gauge_scan_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_restart,
  input  wire logic [1:0] i_clk_sel,
  output logic            o_conv_done,
  output logic            o_slot_end
);

  logic [11:0] count;
  logic [11:0] last;

  // ---------------------------------------------------------------
  // Ratio select
  // ---------------------------------------------------------------
  // ratio from select
  always_comb begin
    case (i_clk_sel)
      2'h0:    last = DIV_LAST_0;
      2'h1:    last = DIV_LAST_1;
      2'h2:    last = DIV_LAST_2;
      default: last = DIV_LAST_3;
    endcase
  end

  // ---------------------------------------------------------------
  // Slot counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_restart) begin
      count <= 12'h000;
    end else if (count >= last) begin
      count <= 12'h000;
    end else begin
      count <= count + 12'h001;
    end
  end

  assign o_conv_done = (count == {1'b0, last[11:1]});
  assign o_slot_end  = (count >= last) && !i_restart;

endmodule : scan_slot_divider

/* File: core/gauge_coil_scan_sequencer.sv */
// Gauge coil scan sequencer with AXI4-Lite register file
// Function
// - Polarity bit one drives current minus to plus, zero plus to minus.
// - Minor D polarity register at index 33 hex, bit 0 only, resets zero.
// - Twelve coils updated one at a time through one shared converter.
// - Scan order major A, B, minor A to D, first coil before second.
// - Automatic mode restarts after last coil; transfers at each gauge update start.
// - Automatic mode ignores new magnitudes until both gauge magnitudes written.
// - Written tracking uses write strobes, not data values.
// - Manual trigger starts exactly one scan, then sequencer halts.
// - Manual mode transfers master to slave every gauge update regardless of writes.
// - Disabled gauge still uses its slots with driver kept off.
// - Each magnitude and direction register has master and slave; slave drives.
// - Per coil: open switches, transfer, load converter, wait, close, settle.
// - Interrupt request when sync enable and sync flag both set.
// - Sync flag set when coil 11 servicing begins, in both modes.
// - Clear bit clears flag only if flag was read set; reads zero.
// - Clock select divides bus clock by 512, 1024, 2048 or 4096.
// - Trigger bit self-clears when coil 11 servicing begins.
// - Trigger write while set ignored; trigger has no effect in automatic.
// - Setting trigger in manual copies every master buffer into its slave.
// - Auto select one chooses automatic scanning, zero manual.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module gauge_coil_scan_sequencer
  import gauge_scan_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output coil_drive_type         o_coil,
  output logic                   o_sync_irq,
  output logic                   o_scan_busy
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return {2'b00, addr[7:2]};
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx >= IDX_MAG_BASE && idx < IDX_MAG_BASE + 8'h0C) ||
           (idx >= IDX_DIR_BASE && idx <= IDX_SCAN_CTRL);
  endfunction : is_mapped

  function automatic logic [2:0] gauge_of(input logic [3:0] coil_idx);
    return coil_idx[3:1];
  endfunction : gauge_of

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0]     aw_addr;
  logic                  aw_held;
  logic [7:0]            w_data;
  logic                  w_lane;
  logic                  w_held;
  logic                  wr_fire;
  logic [7:0]            wr_idx;
  logic                  rd_fire;
  logic [7:0]            rd_idx;
  logic [7:0]            rd_value;

  logic [MAG_W-1:0]      mag_master [NUM_COILS];
  logic [MAG_W-1:0]      mag_slave  [NUM_COILS];
  logic [NUM_COILS-1:0]  mag_wr;
  logic [NUM_COILS-1:0]  mag_hit;
  logic [NUM_COILS-1:0]  xfer_mag;
  logic [NUM_GAUGES-1:0] dir_master;
  logic [NUM_GAUGES-1:0] dir_slave;
  logic [NUM_GAUGES-1:0] dir_hit;
  logic [NUM_GAUGES-1:0] xfer_dir;
  logic [NUM_GAUGES-1:0] pair_ok;
  logic [NUM_GAUGES-1:0] pair_clear;
  logic [NUM_GAUGES-1:0] first_open;
  logic [NUM_GAUGES-1:0] gauge_go;
  logic [NUM_GAUGES-1:0] gauge_en;

  logic                  irq_en;
  logic [1:0]            clk_sel;
  logic                  auto_mode;
  logic                  scan_trig;
  logic                  sync_flag;
  logic                  flag_seen;
  logic                  ctrl_hit;
  logic                  trig_set;
  logic                  sync_set;
  logic                  flag_clr;

  seq_state_type         state;
  seq_state_type         next_state;
  logic [3:0]            coil;
  logic [3:0]            next_coil;
  logic                  conv_done;
  logic                  slot_end;

  // ---------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign wr_fire   = aw_held && w_held && !o_bvalid;
  assign wr_idx    = reg_index(aw_addr);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_held <= 1'b1;
      w_data <= i_wdata[7:0];
      w_lane <= i_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------
  assign o_arready = !o_rvalid;
  assign rd_fire   = i_arvalid && o_arready;
  assign rd_idx    = reg_index(i_araddr);

  always_comb begin
    rd_value = 8'h00;
    if (rd_idx >= IDX_MAG_BASE && rd_idx < IDX_MAG_BASE + 8'h0C) begin
      rd_value = mag_master[4'(rd_idx - IDX_MAG_BASE)];
    end else if (rd_idx >= IDX_DIR_BASE && rd_idx <= IDX_MINOR_D_POL) begin
      rd_value = {7'h00, dir_master[3'(rd_idx - IDX_DIR_BASE)]};
    end else if (rd_idx == IDX_GAUGE_EN) begin
      rd_value = {2'b00, gauge_en};
    end else if (rd_idx == IDX_SCAN_CTRL) begin
      rd_value = {irq_en, sync_flag, 1'b0, clk_sel, 1'b0, auto_mode, scan_trig};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {24'h00_0000, rd_value};
      o_rresp  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Magnitude registers, master and slave
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_COILS; c++) begin : g_coil
      localparam logic [3:0] CI = 4'(c);
      localparam logic [7:0] MI = IDX_MAG_BASE + 8'(c);
      logic sel_ok;
      // second coil follows first coil decision
      assign sel_ok      = CI[0] ? gauge_go[c/2] : pair_ok[c/2];
      assign mag_hit[c]  = wr_fire && w_lane && (wr_idx == MI);
      assign xfer_mag[c] = trig_set ||
                           (state == ST_OPEN && coil == CI && (!auto_mode || sel_ok));

      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          mag_master[c] <= MAG_RESET;
          mag_slave[c]  <= MAG_RESET;
        end else begin
          if (mag_hit[c]) begin
            mag_master[c] <= w_data;
          end
          if (xfer_mag[c]) begin
            mag_slave[c] <= mag_master[c];
          end
        end
      end

      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          mag_wr[c] <= 1'b0;
        end else begin
          mag_wr[c] <= mag_hit[c] || (mag_wr[c] && !pair_clear[c/2]);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Direction registers, master and slave
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_GAUGES; g++) begin : g_gauge
      localparam logic [3:0] FI = 4'(2 * g);
      assign pair_ok[g]    = mag_wr[2*g] && mag_wr[2*g+1];
      assign first_open[g] = (state == ST_OPEN) && (coil == FI);
      assign pair_clear[g] = first_open[g] && auto_mode && pair_ok[g];
      assign dir_hit[g]    = wr_fire && w_lane && (wr_idx == IDX_DIR_BASE + 8'(g));
      assign xfer_dir[g]   = trig_set || (first_open[g] && (!auto_mode || pair_ok[g]));

      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          dir_master[g] <= POL_RESET;
          dir_slave[g]  <= POL_RESET;
          gauge_go[g]   <= 1'b0;
        end else begin
          if (dir_hit[g]) begin
            dir_master[g] <= w_data[POL_BIT];
          end
          if (xfer_dir[g]) begin
            dir_slave[g] <= dir_master[g];
          end
          if (first_open[g]) begin
            gauge_go[g] <= pair_ok[g];
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Gauge enable and scan control register
  // ---------------------------------------------------------------
  assign ctrl_hit = wr_fire && w_lane && (wr_idx == IDX_SCAN_CTRL);
  // ignored while set or in automatic
  assign trig_set = ctrl_hit && w_data[SC_TRIG_BIT] && !auto_mode && !scan_trig;
  assign sync_set = (state == ST_OPEN) && (coil == SYNC_COIL);
  assign flag_clr = ctrl_hit && w_data[SC_CLEAR_BIT] && flag_seen;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      gauge_en <= GAUGE_EN_RESET;
    end else if (wr_fire && w_lane && wr_idx == IDX_GAUGE_EN) begin
      gauge_en <= w_data[5:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_en    <= 1'b0;
      clk_sel   <= CLKSEL_RESET;
      auto_mode <= 1'b0;
    end else if (ctrl_hit) begin
      irq_en    <= w_data[SC_IRQEN_BIT];
      clk_sel   <= w_data[SC_CLKSEL_HI:SC_CLKSEL_LO];
      auto_mode <= w_data[SC_AUTO_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      scan_trig <= 1'b0;
    end else if (trig_set) begin
      scan_trig <= 1'b1;
    end else if (sync_set) begin
      scan_trig <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sync_flag <= 1'b0;
    end else if (sync_set) begin
      sync_flag <= 1'b1;
    end else if (flag_clr) begin
      sync_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flag_seen <= 1'b0;
    end else if (flag_clr) begin
      flag_seen <= 1'b0;
    end else if (rd_fire && rd_idx == IDX_SCAN_CTRL && sync_flag) begin
      flag_seen <= 1'b1;
    end
  end

  assign o_sync_irq  = irq_en && sync_flag;
  assign o_scan_busy = (state != ST_IDLE);

  // ---------------------------------------------------------------
  // Coil sequencer
  // ---------------------------------------------------------------
  scan_slot_divider u_divider (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_restart   (state == ST_IDLE),
    .i_clk_sel   (clk_sel),
    .o_conv_done (conv_done),
    .o_slot_end  (slot_end)
  );

  always_comb begin
    next_state = state;
    next_coil  = coil;
    case (state)
      ST_IDLE: begin
        if (auto_mode || scan_trig) begin
          next_state = ST_OPEN;
          next_coil  = FIRST_COIL;
        end
      end
      ST_OPEN: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_CONV;
      ST_CONV: begin
        if (conv_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (slot_end) begin
          if (coil != LAST_COIL) begin
            next_state = ST_OPEN;
            next_coil  = coil + 4'h1;
          end else if (auto_mode || scan_trig) begin
            next_state = ST_OPEN;
            next_coil  = FIRST_COIL;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      coil  <= FIRST_COIL;
    end else begin
      state <= next_state;
      coil  <= next_coil;
    end
  end

  // ---------------------------------------------------------------
  // Coil driver outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_coil.dac_data <= MAG_RESET;
    end else if (state == ST_LOAD) begin
      o_coil.dac_data <= mag_slave[coil];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_coil.sh_close       <= '0;
      o_coil.dir_neg_to_pos <= '0;
    end else if (state == ST_CONV && conv_done) begin
      o_coil.sh_close <= NUM_COILS'(1) << coil;
      o_coil.dir_neg_to_pos[coil] <= dir_slave[gauge_of(coil)];
    end else if (state != ST_HOLD || slot_end) begin
      o_coil.sh_close <= '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_coil.drive_en <= '0;
    end else begin
      for (int k = 0; k < NUM_COILS; k++) begin
        o_coil.drive_en[k] <= gauge_en[k/2];
      end
    end
  end

endmodule : gauge_coil_scan_sequencer

/* File: tb/gauge_scan_properties.sv */
// Checker of register bus and coil sequencing
`timescale 1ns/1ps
module gauge_scan_properties
  import gauge_scan_pkg::*;
(
  input wire logic           i_mclk,
  input wire logic           i_sys_rst,
  input wire logic           i_bready,
  input wire logic [1:0]     o_bresp,
  input wire logic           o_bvalid,
  input wire logic [31:0]    o_rdata,
  input wire logic           o_rvalid,
  input wire coil_drive_type o_coil,
  input wire logic           o_scan_busy
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic [11:0] last_sh;
  logic [12:0] gap;
  wire         sh_any = |o_coil.sh_close;
  // Last closed coil
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) last_sh <= 12'h800;
    else if (sh_any) last_sh <= o_coil.sh_close;
  end
  // Cycles since last close
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || $rose(sh_any)) gap <= 13'h1;
    else if (gap != 13'h1FFF) gap <= gap + 13'h1;
  end
  // ----------------
  // Checks
  // ----------------
  sequence s_close; $rose(sh_any); endsequence
  property p_bresp; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bresp: assert property (p_bresp) else $error("bresp dropped");
  property p_rdata; o_rvalid |-> o_rdata[31:8] == 24'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("upper read bits set");
  property p_one; $onehot0(o_coil.sh_close); endproperty
  a_one: assert property (p_one) else $error("two coils held");
  property p_order; s_close |-> o_coil.sh_close == {last_sh[10:0], last_sh[11]}; endproperty
  a_order: assert property (p_order) else $error("coil order");
  property p_slot;
    s_close |-> o_coil.sh_close[0] || gap inside {13'h200, 13'h400, 13'h800, 13'h1000};
  endproperty
  a_slot: assert property (p_slot) else $error("slot length");
  property p_dac; sh_any |-> $stable(o_coil.dac_data); endproperty
  a_dac: assert property (p_dac) else $error("dac moved while held");
  property p_dir;
    ((o_coil.dir_neg_to_pos ^ $past(o_coil.dir_neg_to_pos)) & ~o_coil.sh_close) == 12'h0;
  endproperty
  a_dir: assert property (p_dir) else $error("direction off close");
  property p_end; $fell(o_scan_busy) |-> last_sh == 12'h800; endproperty
  a_end: assert property (p_end) else $error("scan stopped early");
endmodule : gauge_scan_properties
bind gauge_coil_scan_sequencer gauge_scan_properties u_props (
  .i_mclk, .i_sys_rst, .i_bready, .o_bresp, .o_bvalid, .o_rdata, .o_rvalid, .o_coil,
  .o_scan_busy
);

/* File: tb/coil_driver_model.sv */
// Sample-and-hold coil driver model
`timescale 1ns/1ps
module coil_driver_model
  import gauge_scan_pkg::*;
(
  input  wire logic           i_mclk,
  input  wire coil_drive_type i_coil,
  output logic [11:0][7:0]    o_held_mag,
  output logic [11:0]         o_held_neg
);
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 12; k++) begin
      if (i_coil.sh_close[k]) begin
        o_held_mag[k] <= i_coil.drive_en[k] ? i_coil.dac_data : 8'h00;
        o_held_neg[k] <= i_coil.dir_neg_to_pos[k];
      end
    end
  end
endmodule : coil_driver_model

/* File: tb/gauge_coil_scan_sequencer_tb_top.sv */
// Bench of the gauge coil scan sequencer
`timescale 1ns/1ps
module gauge_coil_scan_sequencer_tb_top;
  import gauge_scan_pkg::*;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready, o_bvalid, o_arready;
  logic o_rvalid, o_sync_irq, o_scan_busy;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] o_bresp, o_rresp, rr;
  coil_drive_type o_coil;
  logic [11:0][7:0] mag;
  logic [11:0] neg;
  int err_total = 0, comparisons = 0, n;
  always #5 i_mclk = ~i_mclk;
  gauge_coil_scan_sequencer u_dut (
    .i_mclk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .o_coil, .o_sync_irq, .o_scan_busy
  );
  coil_driver_model u_coils (.i_mclk, .i_coil(o_coil), .o_held_mag(mag), .o_held_neg(neg));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic bound(input int lim);
    if (n >= lim) begin
      chk("wait bound", lim, n);
      final_report();
    end
  endtask : bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_awaddr <= {a[5:0], 2'b00};
    i_araddr <= {a[5:0], 2'b00};
    i_wdata <= {24'h0, d};
    i_awvalid <= w;
    i_wvalid <= w;
    i_bready <= w;
    i_arvalid <= !w;
    i_rready <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_arready) i_arvalid <= 1'b0;
      if (o_bvalid || o_rvalid) break;
    end
    rv = o_rdata;
    rr = w ? o_bresp : o_rresp;
    i_bready <= 1'b0;
    i_rready <= 1'b0;
    bound(20);
  endtask : bus
  task automatic wait_busy(input logic b, input int lim);
    for (n = 0; n < lim && o_scan_busy !== b; n++) @(posedge i_mclk);
    bound(lim);
  endtask : wait_busy
  task automatic t_regs;
    bus(0, IDX_MINOR_D_POL, 8'h00);
    chk("pol reset", 32'h0, rv);
    bus(1, IDX_MINOR_D_POL, 8'hFF);
    bus(0, IDX_MINOR_D_POL, 8'h00);
    chk("pol bits", 32'h1, rv);
    bus(1, 8'h3F, 8'h55);
    chk("wr unmapped", 32'(RESP_SLVERR), 32'(rr));
    bus(0, 8'h3F, 8'h00);
    chk("rd unmapped", 32'(RESP_SLVERR), 32'(rr));
    $display("regs done");
  endtask : t_regs
  task automatic t_manual;
    bus(1, IDX_GAUGE_EN, 8'h3E);
    bus(1, IDX_MINOR_D_POL, 8'h01);
    bus(1, IDX_MAG_BASE + 8'h0A, 8'hA5);
    bus(1, IDX_SCAN_CTRL, 8'h81);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 8000);
    chk("scan length", 32'h1, 32'(n > 6139 && n < 6147));
    chk("coil 11 mag", 32'hA5, 32'(mag[10]));
    chk("minor d dir", 32'h3, 32'(neg[11:10]));
    chk("off gauge", 32'h0, 32'(mag[0]));
    chk("irq", 32'h1, 32'(o_sync_irq));
    bus(0, IDX_SCAN_CTRL, 8'h00);
    chk("trig cleared", 32'h0, 32'(rv[0]));
    chk("flag set", 32'h1, 32'(rv[6]));
    bus(1, IDX_SCAN_CTRL, 8'hA0);
    bus(0, IDX_SCAN_CTRL, 8'h00);
    chk("flag clear", 32'h80, rv);
    chk("irq off", 32'h0, 32'(o_sync_irq));
    bus(1, IDX_SCAN_CTRL, 8'h09);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 14000);
    chk("scan 1024", 32'h1, 32'(n > 12283 && n < 12291));
    bus(1, IDX_SCAN_CTRL, 8'h28);
    chk("irq masked", 32'h0, 32'(o_sync_irq));
    bus(0, IDX_SCAN_CTRL, 8'h00);
    chk("clear unread", 32'h48, rv);
    bus(1, IDX_SCAN_CTRL, 8'h20);
    $display("manual done");
  endtask : t_manual
  task automatic t_auto;
    bus(1, IDX_MAG_BASE + 8'h02, 8'h77);
    bus(1, IDX_SCAN_CTRL, 8'h02);
    bus(1, IDX_SCAN_CTRL, 8'h03);
    bus(0, IDX_SCAN_CTRL, 8'h00);
    chk("auto trig", 32'h2, rv);
    repeat (26 * DIV_RATIO_0) @(posedge i_mclk);
    chk("half written", 32'h0, 32'(mag[2]));
    chk("auto rerun", 32'h1, 32'(o_scan_busy));
    bus(1, IDX_MAG_BASE + 8'h03, 8'h00);
    repeat (26 * DIV_RATIO_0) @(posedge i_mclk);
    chk("both written", 32'h77, 32'(mag[2]));
    $display("auto done");
  endtask : t_auto
  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_manual();
    t_auto();
    final_report();
  end
endmodule : gauge_coil_scan_sequencer_tb_top
